/* rdts_regs.vh */
// Purpose: constants for the reference divider and tap selector
// Assumes: byte addresses on a 4-bit Wishbone address
// Notes: included by the divider and top-level design files; the tap selector does not include it
//
// Contract
// - Oscillator clock divided by cascaded binary stages into octaves.
// - Three-stage counter after two halvings; divide-by-eight gives 6-12 MHz.
// - Twelve further binary stages; the eighth of them reaches the 24.4-48.8 kHz octave.
// - Undivided oscillator feeds twice-reference selector via a fixed delay.
// - Tap choice depends on octave code and second-harmonic mode.
// - Selector controls decoded combinationally from four code bits and mode.
// - Control bit 0 is select LSB, bit 2 select MSB, bit 3 enable.
// - Code names detection frequency: reference, or twice it in 2F mode.
// - Detection clock via two cascaded selectors; reference via a third (here two selectors, ORed).
// - Selected reference tap retimed by flip-flops on twice-reference clock.
// - Twice-reference from two selectors, one active, idle one low, ORed.
// - Logic-level reference output enabled only for codes 2-7, MSB low.
// - Enabled output gives true and inverted reference plus twice-reference.
// - Fixed taps: 6-12 MHz chop sync, 24-49 kHz and 49-98 kHz.
// - Fixed 49-98 kHz tap is the source of all sampling clocks.
// - Two-bit loop range code selects one of four filter paths.
// - Comparator up when local lags, down when it leads, idle locked.
// - Lock loss past ten degrees; unlock_freq_up flag high, unlock_freq_down_n flag low.
// - Sampling clock is synchronous with reference and sets sampling rate.
`ifndef RDTS_REGS_VH
`define RDTS_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RDTS_ADR_CTRL 4'h0
`define RDTS_ADR_STATUS 4'h4
`define RDTS_ADR_PERIOD 4'h8
`define RDTS_CTRL_RESET 8'h02
`define RDTS_F_MODE 4
`define RDTS_F_LR_LO 5
`define RDTS_F_LR_HI 6
`define RDTS_F_INTMODE 7

// ----------------------------------------------------------------
// Divider layout and taps
// ----------------------------------------------------------------
`define RDTS_CNT_W 18
`define RDTS_TAP_CHOP 5
`define RDTS_TAP_49K 12
`define RDTS_TAP_24K 13
`define RDTS_DET_TOP 5'h0f
`define RDTS_CODE_MIN 4'h2
`define RDTS_CODE_MAX 4'he
`define RDTS_BASE_HI 5'h01
`define RDTS_BASE_LO 5'h09
`define RDTS_BASE_2HI 5'h00
`define RDTS_BASE_2LO 5'h08
`define RDTS_DET_SPLIT 5'h08

// ----------------------------------------------------------------
// Lock sensing: 360 degrees over a 10 degree excursion
// ----------------------------------------------------------------
`define RDTS_MEAS_W 20
`define RDTS_LOCK_RATIO 26'h0000024

`endif

/* rdts_divider.v */
// Purpose: binary divider chain of the reference clock
// Assumes: taps[0] stands in for the oscillator waveform
// Notes: one synchronous counter replaces the ripple stages
`timescale 1ns/1ns
`include "rdts_regs.vh"

module rdts_divider (
    input wire mclk,
    input wire rst_b,
    output reg [`RDTS_CNT_W-1:0] taps,
    output reg osc_dly
);

// ----------------------------------------------------------------
// Stages: [0] osc, [2:1] halvings, [5:3] 3-stage, [17:6] 12-stage
// ----------------------------------------------------------------
// Synchronous count keeps every octave edge-aligned, unlike ripple
always @(posedge mclk) begin
    if (!rst_b) begin
        taps <= {`RDTS_CNT_W{1'b0}};
        osc_dly <= 1'b0;
    end else begin
        taps <= taps + {{(`RDTS_CNT_W-1){1'b0}}, 1'b1};
        osc_dly <= taps[0];
    end
end

endmodule

/* rdts_tap_mux.v */
// Purpose: eight-way gated tap selector
// Assumes: ctl decoded by the caller
// Notes: a disabled selector holds its output low
`timescale 1ns/1ns

module rdts_tap_mux (
    input wire mclk,
    input wire rst_b,
    input wire [7:0] taps,
    input wire [3:0] ctl,
    output reg tap_out
);

// ----------------------------------------------------------------
// Select and gate
// ----------------------------------------------------------------
always @(posedge mclk) begin
    if (!rst_b) begin
        tap_out <= 1'b0;
    end else begin
        tap_out <= ctl[3] & taps[ctl[2:0]];
    end
end

endmodule

/* rdts_top.v */
// Purpose: tap selection, retiming, lock sensing and register slave
// Assumes: ext_ref is synchronous to mclk
// Notes: selector outputs carry one cycle of latency each
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "rdts_regs.vh"

module rdts_top (
    input wire mclk,
    input wire rst_b,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire ext_ref,
    input wire synth_pump_up,
    input wire synth_pump_down,
    output reg det_clk,
    output reg ref_loop_clk,
    output reg ref_out_clk,
    output reg ref2x_clk,
    output reg ttl_ref_p,
    output reg ttl_ref_n,
    output reg ttl_ref2x,
    output reg chop_sync_clk,
    output reg fix_24k_clk,
    output reg fix_49k_clk,
    output reg sample_clk,
    output reg pump_up,
    output reg pump_down,
    output reg [3:0] filt_path,
    output reg unlock_freq_up,
    output reg unlock_freq_down_n
);

// ----------------------------------------------------------------
// Decode helpers
// ----------------------------------------------------------------
function [3:0] tap_ctl;
    input [4:0] idx;
    input [4:0] base;
    reg [4:0] off;
    begin
        off = idx - base;
        if (idx >= base && off < 5'h08) begin
            tap_ctl = {1'b1, off[2:0]};
        end else begin
            tap_ctl = 4'h0;
        end
    end
endfunction

// Excursion past ten degrees: width * 36 exceeds the period
function lock_lost;
    input [`RDTS_MEAS_W-1:0] width;
    input [`RDTS_MEAS_W-1:0] period;
    reg [25:0] prod;
    begin
        prod = {6'h00, width} * `RDTS_LOCK_RATIO;
        lock_lost = (period != {`RDTS_MEAS_W{1'b0}}) &&
            (prod > {6'h00, period});
    end
endfunction

function rise;
    input now;
    input was;
    begin
        rise = now & ~was;
    end
endfunction

// ----------------------------------------------------------------
// Control register
// ----------------------------------------------------------------
reg [7:0] ctrl;
wire octave_code_bit3;
wire octave_code_bit2;
wire octave_code_bit1;
wire octave_code_bit0;
wire second_harmonic_flag;
wire loop_range_hi;
wire loop_range_lo;
wire int_mode;
wire [3:0] code;

assign octave_code_bit0 = ctrl[0];
assign octave_code_bit1 = ctrl[1];
assign octave_code_bit2 = ctrl[2];
assign octave_code_bit3 = ctrl[3];
assign second_harmonic_flag = ctrl[`RDTS_F_MODE];
assign loop_range_lo = ctrl[`RDTS_F_LR_LO];
assign loop_range_hi = ctrl[`RDTS_F_LR_HI];
assign int_mode = ctrl[`RDTS_F_INTMODE];
// First bit of the code is its MSB
assign code = {octave_code_bit3, octave_code_bit2,
    octave_code_bit1, octave_code_bit0};

// ----------------------------------------------------------------
// Divider chain
// ----------------------------------------------------------------
wire [`RDTS_CNT_W-1:0] taps;
wire osc_dly;

rdts_divider u_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps(taps),
    .osc_dly(osc_dly)
);

// ----------------------------------------------------------------
// Selector control decode, purely from code and mode
// ----------------------------------------------------------------
reg code_ok;
reg [4:0] det_idx;
reg [4:0] ref_idx;
reg [4:0] two_idx;
reg [4:0] det_off;
reg [3:0] ctl_det1;
reg [3:0] ctl_det2;
reg [3:0] ctl_ref_hi;
reg [3:0] ctl_ref_lo;
reg [3:0] ctl_two_hi;
reg [3:0] ctl_two_lo;

always @* begin
    code_ok = (code >= `RDTS_CODE_MIN) && (code <= `RDTS_CODE_MAX);
    // Code names the detection octave; 2F puts reference one lower
    det_idx = `RDTS_DET_TOP - {1'b0, code};
    ref_idx = det_idx + {4'h0, second_harmonic_flag};
    two_idx = ref_idx - 5'h01;
    det_off = det_idx - `RDTS_DET_SPLIT;
    ctl_det1 = tap_ctl(det_idx, `RDTS_BASE_HI);
    if (!code_ok) begin
        ctl_det2 = 4'h0;
    end else if (det_idx <= `RDTS_DET_SPLIT) begin
        ctl_det2 = 4'h8;
    end else begin
        ctl_det2 = {1'b1, det_off[2:0]};
    end
    if (code_ok) begin
        ctl_ref_hi = tap_ctl(ref_idx, `RDTS_BASE_HI);
        ctl_ref_lo = tap_ctl(ref_idx, `RDTS_BASE_LO);
        ctl_two_hi = tap_ctl(two_idx, `RDTS_BASE_2HI);
        ctl_two_lo = tap_ctl(two_idx, `RDTS_BASE_2LO);
    end else begin
        ctl_ref_hi = 4'h0;
        ctl_ref_lo = 4'h0;
        ctl_two_hi = 4'h0;
        ctl_two_lo = 4'h0;
    end
end

// ----------------------------------------------------------------
// Tap selectors
// ----------------------------------------------------------------
wire det_stage1;
wire det_stage2;
wire ref_hi;
wire ref_lo;
wire two_hi;
wire two_lo;

// Stage 1 adds a cycle to fast taps; harmless at these octaves
rdts_tap_mux u_det1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps(taps[8:1]),
    .ctl(ctl_det1),
    .tap_out(det_stage1)
);

rdts_tap_mux u_det2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps({taps[15:9], det_stage1}),
    .ctl(ctl_det2),
    .tap_out(det_stage2)
);

rdts_tap_mux u_ref_hi (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps(taps[8:1]),
    .ctl(ctl_ref_hi),
    .tap_out(ref_hi)
);

rdts_tap_mux u_ref_lo (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps(taps[16:9]),
    .ctl(ctl_ref_lo),
    .tap_out(ref_lo)
);

rdts_tap_mux u_two_hi (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps({taps[7:1], osc_dly}),
    .ctl(ctl_two_hi),
    .tap_out(two_hi)
);

rdts_tap_mux u_two_lo (
    .mclk(mclk),
    .rst_b(rst_b),
    .taps(taps[15:8]),
    .ctl(ctl_two_lo),
    .tap_out(two_lo)
);

// ----------------------------------------------------------------
// Reference retiming on the twice-reference clock
// ----------------------------------------------------------------
reg two_q;
reg two_d;
reg ref_loop;
reg ref_outq;
wire ref_sel;

assign ref_sel = ref_hi | ref_lo;

always @(posedge mclk) begin
    if (!rst_b) begin
        two_q <= 1'b0;
        two_d <= 1'b0;
        ref_loop <= 1'b0;
        ref_outq <= 1'b0;
    end else begin
        two_q <= two_hi | two_lo;
        two_d <= two_q;
        if (rise(two_q, two_d)) begin
            ref_loop <= ref_sel;
            ref_outq <= ref_sel;
        end
    end
end

// ----------------------------------------------------------------
// Phase comparator and lock sensing
// ----------------------------------------------------------------
reg ext_q;
reg ext_d;
reg loc_d;
reg pd_up;
reg pd_dn;
reg [`RDTS_MEAS_W-1:0] per_cnt;
reg [`RDTS_MEAS_W-1:0] ref_period;
reg [`RDTS_MEAS_W-1:0] up_w;
reg [`RDTS_MEAS_W-1:0] dn_w;
wire ext_edge;
wire loc_edge;
wire [`RDTS_MEAS_W-1:0] one_w;

assign one_w = {{(`RDTS_MEAS_W-1){1'b0}}, 1'b1};
assign ext_edge = rise(ext_q, ext_d);
assign loc_edge = rise(ref_loop, loc_d);

always @(posedge mclk) begin
    if (!rst_b) begin
        ext_q <= 1'b0;
        ext_d <= 1'b0;
        loc_d <= 1'b0;
        pd_up <= 1'b0;
        pd_dn <= 1'b0;
        per_cnt <= {`RDTS_MEAS_W{1'b0}};
        ref_period <= {`RDTS_MEAS_W{1'b0}};
        up_w <= {`RDTS_MEAS_W{1'b0}};
        dn_w <= {`RDTS_MEAS_W{1'b0}};
    end else begin
        ext_q <= ext_ref;
        ext_d <= ext_q;
        loc_d <= ref_loop;
        // Both pending means the edges met: reset, as a locked PFD
        if ((pd_up | ext_edge) & (pd_dn | loc_edge)) begin
            pd_up <= 1'b0;
            pd_dn <= 1'b0;
        end else begin
            pd_up <= pd_up | ext_edge;
            pd_dn <= pd_dn | loc_edge;
        end
        if (loc_edge) begin
            ref_period <= per_cnt;
            per_cnt <= one_w;
        end else if (~&per_cnt) begin
            per_cnt <= per_cnt + one_w;
        end
        if (!pd_up) begin
            up_w <= {`RDTS_MEAS_W{1'b0}};
        end else if (~&up_w) begin
            up_w <= up_w + one_w;
        end
        if (!pd_dn) begin
            dn_w <= {`RDTS_MEAS_W{1'b0}};
        end else if (~&dn_w) begin
            dn_w <= dn_w + one_w;
        end
    end
end

// ----------------------------------------------------------------
// Registered outputs
// ----------------------------------------------------------------
wire ttl_en;

assign ttl_en = code_ok & ~octave_code_bit3;

always @(posedge mclk) begin
    if (!rst_b) begin
        det_clk <= 1'b0;
        ref_loop_clk <= 1'b0;
        ref_out_clk <= 1'b0;
        ref2x_clk <= 1'b0;
        ttl_ref_p <= 1'b0;
        ttl_ref_n <= 1'b0;
        ttl_ref2x <= 1'b0;
        chop_sync_clk <= 1'b0;
        fix_24k_clk <= 1'b0;
        fix_49k_clk <= 1'b0;
        sample_clk <= 1'b0;
        pump_up <= 1'b0;
        pump_down <= 1'b0;
        filt_path <= 4'h1;
        unlock_freq_up <= 1'b0;
        unlock_freq_down_n <= 1'b1;
    end else begin
        det_clk <= det_stage2;
        ref_loop_clk <= ref_loop;
        ref_out_clk <= ref_outq;
        ref2x_clk <= two_q;
        // Both legs idle low while disabled, not complementary
        ttl_ref_p <= ttl_en & ref_outq;
        ttl_ref_n <= ttl_en & ~ref_outq;
        ttl_ref2x <= ttl_en & two_q;
        chop_sync_clk <= taps[`RDTS_TAP_CHOP];
        fix_24k_clk <= taps[`RDTS_TAP_24K];
        fix_49k_clk <= taps[`RDTS_TAP_49K];
        sample_clk <= taps[`RDTS_TAP_49K];
        // Internal mode: comparator lives in the synthesiser
        pump_up <= int_mode ? synth_pump_up : pd_up;
        pump_down <= int_mode ? synth_pump_down : pd_dn;
        case ({loop_range_hi, loop_range_lo})
            2'h0: filt_path <= 4'h1;
            2'h1: filt_path <= 4'h2;
            2'h2: filt_path <= 4'h4;
            default: filt_path <= 4'h8;
        endcase
        unlock_freq_up <= pd_up & lock_lost(up_w, ref_period);
        unlock_freq_down_n <= ~(pd_dn & lock_lost(dn_w, ref_period));
    end
end

// ----------------------------------------------------------------
// Wishbone classic slave, one wait state
// ----------------------------------------------------------------
wire wb_req;

assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

always @(posedge mclk) begin
    if (!rst_b) begin
        ctrl <= `RDTS_CTRL_RESET;
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= wb_req;
        if (wb_req && wb_we_i && wb_sel_i[0] &&
                wb_adr_i == `RDTS_ADR_CTRL) begin
            ctrl <= wb_dat_i[7:0];
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `RDTS_ADR_CTRL: wb_dat_o <= {24'h000000, ctrl};
                `RDTS_ADR_STATUS: wb_dat_o <= {27'h0000000, ttl_en,
                    pd_dn, pd_up, unlock_freq_down_n, unlock_freq_up};
                `RDTS_ADR_PERIOD: wb_dat_o <= {12'h000, ref_period};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

endmodule

/* rdts_props_properties.sv */
// Purpose: port-level checks of the divider and tap selector
// Assumes: control byte shadowed from the bus writes seen at the ports
// Notes: bound to rdts_top; age gives outputs time to settle
`timescale 1ns/1ns
module rdts_props (
    input wire mclk,
    input wire rst_b,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire synth_pump_up,
    input wire synth_pump_down,
    input wire pump_up,
    input wire pump_down,
    input wire ttl_ref_p,
    input wire ttl_ref_n,
    input wire ttl_ref2x,
    input wire chop_sync_clk,
    input wire fix_24k_clk,
    input wire fix_49k_clk,
    input wire sample_clk,
    input wire [3:0] filt_path
);
// ----------------------------------------
// Shadow of control and tap counters
// ----------------------------------------
reg [7:0] shadow;
reg [7:0] age;
reg [5:0] gap;
reg seen;
wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wr_ctrl = take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
wire ttl_on = shadow[3:0] >= 4'h2 && !shadow[3];
always @(posedge mclk) begin
    if (!rst_b) begin
        shadow <= 8'h02;
        age <= 8'h00;
        gap <= 6'h00;
        seen <= 1'b0;
    end else begin
        shadow <= wr_ctrl ? wb_dat_i[7:0] : shadow;
        age <= wr_ctrl ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
        gap <= $changed(chop_sync_clk) ? 6'h00 : gap + 6'h01;
        seen <= seen | $changed(chop_sync_clk);
    end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_b);
sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
endsequence
a_bus_answer: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse one cycle after request");
a_ttl_gate: assert property ((age > 8'd16 && !ttl_on) |->
    !ttl_ref_p && !ttl_ref_n && !ttl_ref2x)
    else $error("logic reference active outside codes 2 to 7");
a_ttl_compl: assert property ((age > 8'd16 && ttl_on) |->
    ttl_ref_n == !ttl_ref_p)
    else $error("logic reference outputs not complementary");
a_filt_decode: assert property ((age > 8'd4) |->
    filt_path == (4'h1 << shadow[6:5]))
    else $error("filter path does not match loop range code");
a_pump_follow: assert property ((age > 8'd4 && shadow[7]) |=>
    pump_up == $past(synth_pump_up) && pump_down == $past(synth_pump_down))
    else $error("pump outputs not following synthesiser in internal mode");
a_pump_excl: assert property ((age > 8'd4 && !shadow[7]) |->
    !(pump_up && pump_down))
    else $error("up and down pump both active");
a_sample_tap: assert property (sample_clk == fix_49k_clk)
    else $error("sampling clock differs from fixed 49k tap");
a_carry_24k: assert property ($changed(fix_24k_clk) |->
    $fell(fix_49k_clk))
    else $error("24k tap moved without carry from 49k tap");
a_carry_49k: assert property ($changed(fix_49k_clk) |->
    $fell(chop_sync_clk))
    else $error("49k tap moved without carry from chop tap");
a_chop_period: assert property (($changed(chop_sync_clk) && seen) |->
    gap == 6'd31)
    else $error("chop tap half period not 32 cycles");
a_reset_clear: assert property (disable iff (1'b0) !rst_b |=>
    !wb_ack_o && filt_path == 4'h1 && !ttl_ref_p && !pump_up)
    else $error("outputs not cleared by reset");
endmodule

bind rdts_top rdts_props u_props (.mclk(mclk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .synth_pump_up(synth_pump_up),
    .synth_pump_down(synth_pump_down), .pump_up(pump_up),
    .pump_down(pump_down), .ttl_ref_p(ttl_ref_p), .ttl_ref_n(ttl_ref_n),
    .ttl_ref2x(ttl_ref2x), .chop_sync_clk(chop_sync_clk),
    .fix_24k_clk(fix_24k_clk), .fix_49k_clk(fix_49k_clk),
    .sample_clk(sample_clk), .filt_path(filt_path));

/* rdts_ref_source.sv */
// Purpose: far-side reference source and synthesiser pump pins
// Assumes: half_cyc of zero means no reference present
// Notes: all outputs registered on mclk
`timescale 1ns/1ns
module rdts_ref_source (
    input wire mclk,
    input wire rst_b,
    input wire [15:0] half_cyc,
    input wire [1:0] pump_lvl,
    output reg ext_ref,
    output reg synth_pump_up,
    output reg synth_pump_down
);
reg [15:0] cnt;
always @(posedge mclk) begin
    if (!rst_b || half_cyc == 16'h0000) begin
        cnt <= 16'h0000;
        ext_ref <= 1'b0;
    end else if (cnt >= half_cyc - 16'h0001) begin
        cnt <= 16'h0000;
        ext_ref <= !ext_ref;
    end else begin
        cnt <= cnt + 16'h0001;
    end
    synth_pump_up <= rst_b & pump_lvl[0];
    synth_pump_down <= rst_b & pump_lvl[1];
end
endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the divider and tap selector
// Assumes: control model held as an integer in the bench
// Notes: codes 8-14 timed in full; lower codes too slow to time
`timescale 1ns/1ns
module tb_top;
reg mclk = 1'b0;
reg rst_b = 1'b0;
reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
reg [31:0] wb_dat_i = 32'h0, rng = 32'h62;
reg [15:0] half_cyc = 16'h0000;
reg [1:0] pump_lvl = 2'h0;
wire [31:0] wb_dat_o;
wire [3:0] filt_path;
wire wb_ack_o, ext_ref, synth_pump_up, synth_pump_down, det_clk;
wire ref_loop_clk, ref_out_clk, ref2x_clk, ttl_ref_p, ttl_ref_n, ttl_ref2x;
wire chop_sync_clk, fix_24k_clk, fix_49k_clk, sample_clk, pump_up;
wire pump_down, unlock_freq_up, unlock_freq_down_n;
int err_count = 0, checks_done = 0, cycles = 0, ctrl_m;
always #5 mclk = ~mclk;
rdts_top i_dut (.*);
rdts_ref_source i_src (.mclk(mclk), .rst_b(rst_b), .half_cyc(half_cyc),
    .pump_lvl(pump_lvl), .ext_ref(ext_ref), .synth_pump_up(synth_pump_up),
    .synth_pump_down(synth_pump_down));
// ----------------------------------------
// Helpers
// ----------------------------------------
function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
endfunction
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
        err_count++;
        tally_and_finish;
    end
end
task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
        err_count++;
        $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
endtask
task automatic wb(input logic w, logic [3:0] a, logic [31:0] d,
                  output logic [31:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
endtask
function logic pick(input int k);
    case (k)
        0: return det_clk;
        1: return ref_loop_clk;
        2: return chop_sync_clk;
        4: return ref_out_clk;
        5: return ref2x_clk;
        default: return sample_clk;
    endcase
endfunction
// Counts edges between two changes of the chosen clock
task automatic chk_half(input string what, input int k, input int e);
    int n;
    logic v;
    v = pick(k);
    @(posedge mclk);
    while (pick(k) === v) @(posedge mclk);
    v = pick(k);
    n = 0;
    while (pick(k) === v) begin
        @(posedge mclk);
        n++;
    end
    chk(what, e, n);
endtask
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial begin
    logic [31:0] q;
    int code, md, lr, n;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    wb(0, 4'h0, 0, q);
    chk("ctrl reset", 32'h02, q);
    for (code = 0; code < 16; code++) begin
        rng = xs(rng);
        md = rng[0];
        lr = rng[2:1];
        ctrl_m = code | (md << 4) | (lr << 5);
        wb(1, 4'h0, ctrl_m, q);
        wb(0, 4'h0, 0, q);
        chk("ctrl", ctrl_m, q);
        chk("filt", 1 << lr, filt_path);
        repeat (20) @(posedge mclk);
        wb(0, 4'h4, 0, q);
        chk("ttl en", code >= 2 && code <= 7, q[4]);
        if (code >= 8 && code <= 14) begin
            chk_half("det", 0, 1 << (15 - code));
            chk_half("ref", 1, 1 << (15 - code + md));
            chk_half("ref out", 4, 1 << (15 - code + md));
            chk_half("ref 2x", 5, 1 << (14 - code + md));
        end
        if (code >= 2 && code <= 7) begin
            chk("ttl n", !ttl_ref_p, ttl_ref_n);
            chk("ttl p", ref_out_clk, ttl_ref_p);
            chk("ttl 2x", ref2x_clk, ttl_ref2x);
        end
        if (code < 2 || code > 7)
            chk("ttl off", 0, ttl_ref_p | ttl_ref_n | ttl_ref2x);
    end
    $display("test code sweep done");
    wb(1, 4'h4, 32'hffffffff, q);
    wb(0, 4'hc, 0, q);
    chk("unmapped", 0, q);
    wb(0, 4'h0, 0, q);
    chk("ctrl kept", ctrl_m, q);
    chk_half("chop", 2, 32);
    chk_half("sample", 3, 4096);
    $display("test fixed taps done");
    ctrl_m = 8'h80 | 8'h0e | (2 << 5);
    wb(1, 4'h0, ctrl_m, q);
    repeat (4) @(posedge mclk);
    repeat (8) begin
        rng = xs(rng);
        pump_lvl <= rng[1:0];
        repeat (3) @(posedge mclk);
        chk("pump", rng[1:0], {pump_down, pump_up});
    end
    $display("test internal mode done");
    wb(1, 4'h0, 8'h0e, q);
    half_cyc <= 16'h0007;
    n = 0;
    while (unlock_freq_up !== 1'b1 && unlock_freq_down_n !== 1'b0
           && n < 400) begin
        @(posedge mclk);
        n++;
    end
    chk("unlock", 1, n < 400);
    chk("unlock up", 0, unlock_freq_up);
    wb(0, 4'h8, 0, q);
    chk("period", 4, q);
    $display("test lock loss done");
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    wb(0, 4'h0, 0, q);
    chk("ctrl rerst", 32'h02, q);
    $display("test second reset done");
    tally_and_finish;
end
endmodule
